// ### logic/cg_clk_sw.sv
`timescale 1ns/1ns
module cg_clk_sw
  import cg_pkg::*;
#(
  parameter int W = 1,
  parameter logic [SW_CNT_W-1:0] DLY = 4'h1
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Requested and applied selection
  input wire logic [W-1:0] req_i,
  output logic [W-1:0] val_o
);

  typedef struct packed {
    logic [W-1:0] tgt;
    logic [W-1:0] val;
    logic [SW_CNT_W-1:0] cnt;
  } cg_sw_state_t;

  cg_sw_state_t s_q;
  cg_sw_state_t s_d;

  // A new request restarts the wait, so glitchy software never half-switches
  always_comb
  begin
    s_d = s_q;
    if (req_i != s_q.tgt)
    begin
      s_d.tgt = req_i;
      s_d.cnt = DLY;
    end
    else if (s_q.cnt != '0)
      s_d.cnt = s_q.cnt - 1'b1;
    else
      s_d.val = s_q.tgt;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  assign val_o = s_q.val;

endmodule

// ### logic/cg_clock_gen.sv
`timescale 1ns/1ns
// What this block does
// - Reset: external oscillator off, internal running, PLL off, gear undivided.
// - PLL never runs from the internal oscillator; software must not try.
// - PLL multiplies an 8 to 16 MHz input by 12, 8 or 6.
// - To change multiplier: deselect, poll status zero, power off, rewrite, relock.
// - Internal, external crystal or external clock feed fc; only external via PLL.
// - Gear code 000 divides by one; new ratio applies after a short delay.
// - High-speed clock stays at or under 24 MHz in every combination.
// - Peripheral clocks mostly off after reset; writing one supplies a clock.
// - Deep-stop exit uses a warm-up time programmed beforehand in normal mode.
// - Wake from deep stop resumes at the waking interrupt's service routine.
// - External clock halve select: zero passes full rate, one halves it.
module cg_clock_gen
  import cg_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [STRB_W-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Core events
  input wire logic wfi_i,
  input wire logic wake_irq_valid_i,
  input wire logic [IRQ_W-1:0] wake_irq_id_i,
  // Clock controls
  output cg_clk_out_t clk_ctl_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [GEAR_W-1:0] gear;
    logic iosc_en;
    logic [EOSC_W-1:0] eosc_en;
    logic osc_sel;
    logic [STBY_W-1:0] stby;
    logic pll_sel;
    logic pll_on;
    logic [MULT_W-1:0] pll_set;
    logic wu_clk;
    logic [WUPT_W-1:0] wupt;
    logic wu_run;
    logic wu_load;
    logic [DATA_W-1:0] pen_a;
    logic [DATA_W-1:0] pen_b;
    logic ext_half;
    logic tmr_en;
    cg_pm_t pm;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    cg_clk_out_t out;
  } cg_main_state_t;

  cg_main_state_t s_q;
  cg_main_state_t s_d;

  logic oscf;
  logic pll_st;
  logic [GEAR_W-1:0] gear_app;
  logic wu_done;
  logic pll_ok;
  cg_mul_t mul;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic cg_mul_t mul_decode(input logic [MULT_W-1:0] v);
    cg_mul_t m;
    m = CG_MUL_OFF;
    if (v == MULT_X12)
      m = CG_MUL_12;
    else if (v == MULT_X8)
      m = CG_MUL_8;
    else if (v == MULT_X6)
      m = CG_MUL_6;
    return m;
  endfunction

  // Returns {hit, word}
  function automatic logic [DATA_W:0] rd_word(input cg_main_state_t st,
                                              input logic f_osc,
                                              input logic f_pll,
                                              input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    logic hit;
    w = '0;
    hit = 1'b1;
    unique case (a)
      OFF_SYS: w[GEAR_LSB +: GEAR_W] = st.gear;
      OFF_OSC:
      begin
        w[OSC_IOSC_BIT] = st.iosc_en;
        w[OSC_EOSC_LSB +: EOSC_W] = st.eosc_en;
        w[OSC_SEL_BIT] = st.osc_sel;
        w[OSC_FLAG_BIT] = f_osc;
      end
      OFF_STBY: w[STBY_LSB +: STBY_W] = st.stby;
      OFF_PLLSEL:
      begin
        w[PLL_SEL_BIT] = st.pll_sel;
        w[PLL_ST_BIT] = f_pll;
        w[PLL_ON_BIT] = st.pll_on;
      end
      OFF_PLLSET: w[MULT_LSB +: MULT_W] = st.pll_set;
      OFF_WUP:
      begin
        w[WU_FLAG_BIT] = ~st.wu_run;
        w[WU_CLK_BIT] = st.wu_clk;
        w[WUPT_LSB +: WUPT_W] = st.wupt;
      end
      OFF_PENA: w = st.pen_a;
      OFF_PENB: w = st.pen_b;
      OFF_EXT:
      begin
        w[EXT_HALF_BIT] = st.ext_half;
        w[EXT_TMR_BIT] = st.tmr_en;
      end
      default: hit = 1'b0;
    endcase
    return {hit, w};
  endfunction

  // ------------------------------------------------------------
  // Switch-over and warm-up helpers
  // ------------------------------------------------------------
  assign mul = mul_decode(s_q.pll_set);
  // The PLL only ever sees the external source
  assign pll_ok = s_q.pll_on && s_q.osc_sel && oscf && (mul != CG_MUL_OFF);

  cg_clk_sw #(.W(1), .DLY(OSC_SW_CYC)) u_osc_sw (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .req_i(s_q.osc_sel),
    .val_o(oscf)
  );

  cg_clk_sw #(.W(1), .DLY(PLL_SW_CYC)) u_pll_sw (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .req_i(s_q.pll_sel && pll_ok),
    .val_o(pll_st)
  );

  // Gear ratio lands a few cycles after the write
  cg_clk_sw #(.W(GEAR_W), .DLY(GEAR_SW_CYC)) u_gear_sw (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .req_i(s_q.gear),
    .val_o(gear_app)
  );

  cg_timer #(.W(WUPT_W)) u_warmup (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .load_i(s_q.wu_load),
    .value_i(s_q.wupt),
    .busy_o(),
    .done_o(wu_done)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [DATA_W:0] rd;
    logic [DATA_W:0] wr_old;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] wv;
    rd = '0;
    wr_old = '0;
    mask = '0;
    wv = '0;
    s_d = s_q;
    s_d.wu_load = 1'b0;
    s_d.out.wake = 1'b0;

    // Write address and data are taken independently
    if (s_q.awready && s_axi_awvalid_i)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr_i;
    end
    if (s_q.wready && s_axi_wvalid_i)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata_i;
      s_d.w_strb = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i)
      s_d.bvalid = 1'b0;

    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      wr_old = rd_word(s_q, oscf, pll_st, s_q.aw_addr);
      for (int i = 0; i < STRB_W; i++)
        mask[i*8 +: 8] = {8{s_q.w_strb[i]}};
      wv = (wr_old[DATA_W-1:0] & ~mask) | (s_q.w_data & mask);
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_old[DATA_W] ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.aw_addr)
        OFF_SYS: s_d.gear = wv[GEAR_LSB +: GEAR_W];
        OFF_OSC:
        begin
          s_d.iosc_en = wv[OSC_IOSC_BIT];
          s_d.eosc_en = wv[OSC_EOSC_LSB +: EOSC_W];
          s_d.osc_sel = wv[OSC_SEL_BIT];
        end
        OFF_STBY:
        begin
          // Only the two defined codes are kept
          if (wv[STBY_LSB +: STBY_W] == STBY_IDLE || wv[STBY_LSB +: STBY_W] == STBY_DEEP)
            s_d.stby = wv[STBY_LSB +: STBY_W];
        end
        OFF_PLLSEL:
        begin
          s_d.pll_sel = wv[PLL_SEL_BIT];
          s_d.pll_on = wv[PLL_ON_BIT];
        end
        OFF_PLLSET: s_d.pll_set = wv[MULT_LSB +: MULT_W];
        OFF_WUP:
        begin
          s_d.wu_clk = wv[WU_CLK_BIT];
          s_d.wupt = wv[WUPT_LSB +: WUPT_W];
          if (wv[WU_START_BIT])
          begin
            s_d.wu_load = 1'b1;
            s_d.wu_run = 1'b1;
          end
        end
        OFF_PENA: s_d.pen_a = wv;
        OFF_PENB: s_d.pen_b = wv;
        OFF_EXT:
        begin
          s_d.ext_half = wv[EXT_HALF_BIT];
          s_d.tmr_en = wv[EXT_TMR_BIT];
        end
        default: ;
      endcase
    end

    // Reads answer one cycle after the address is taken
    if (s_q.arready && s_axi_arvalid_i)
    begin
      rd = rd_word(s_q, oscf, pll_st, s_axi_araddr_i);
      s_d.rvalid = 1'b1;
      s_d.rdata = rd[DATA_W-1:0];
      s_d.rresp = rd[DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready_i)
      s_d.rvalid = 1'b0;

    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready = !s_d.w_full && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    unique case (s_q.pm)
      CG_PM_NORMAL:
      begin
        if (wfi_i && s_q.stby == STBY_DEEP)
          s_d.pm = CG_PM_STOP;
      end
      CG_PM_STOP:
      begin
        // Warm-up time was programmed before the stop
        if (wake_irq_valid_i)
        begin
          s_d.pm = CG_PM_WARM;
          s_d.out.wake_id = wake_irq_id_i;
          s_d.wu_load = 1'b1;
          s_d.wu_run = 1'b1;
        end
      end
      CG_PM_WARM:
      begin
        if (wu_done)
        begin
          s_d.pm = CG_PM_NORMAL;
          s_d.out.wake = 1'b1;
        end
      end
      default: s_d.pm = CG_PM_NORMAL;
    endcase

    // Set wins: a fresh start in the done cycle keeps the flag busy
    if (wu_done && !s_d.wu_load)
      s_d.wu_run = 1'b0;

    // ------------------------------------------------------------
    // Clock outputs
    // ------------------------------------------------------------
    s_d.out.stop = (s_d.pm == CG_PM_STOP);
    if (s_d.pm == CG_PM_NORMAL)
    begin
      // Internal oscillator cannot be stopped while it still feeds fc
      s_d.out.iosc_en = s_q.iosc_en || !oscf;
      s_d.out.eosc_en = s_q.eosc_en;
      s_d.out.pll_power = pll_ok;
    end
    else
    begin
      s_d.out.iosc_en = (s_d.pm == CG_PM_WARM);
      s_d.out.eosc_en = EOSC_OFF;
      s_d.out.pll_power = 1'b0;
    end
    s_d.out.pll_mul = mul;
    // PLL output reaches fc only at quarter rate, capping it at 24 MHz
    if (!oscf)
      s_d.out.fc_src = CG_SRC_INT;
    else if (pll_st && s_d.out.pll_power)
      s_d.out.fc_src = CG_SRC_PLL;
    else if (s_q.ext_half)
      s_d.out.fc_src = CG_SRC_EXT_HALF;
    else
      s_d.out.fc_src = CG_SRC_EXT;
    s_d.out.gear = gear_app;
    s_d.out.periph_a = s_q.pen_a;
    s_d.out.periph_b = s_q.pen_b;
    s_d.out.timer_pll_en = s_q.tmr_en && s_d.out.pll_power;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
      // Internal oscillator only, undivided
      s_q.gear <= GEAR_DIV1;
      s_q.iosc_en <= 1'b1;
      s_q.eosc_en <= EOSC_OFF;
      s_q.stby <= STBY_IDLE;
      s_q.wupt <= WUPT_RST;
      s_q.pen_a <= PENA_RST;
      s_q.pen_b <= PENB_RST;
      s_q.pm <= CG_PM_NORMAL;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.out.iosc_en <= 1'b1;
      s_q.out.eosc_en <= EOSC_OFF;
      s_q.out.fc_src <= CG_SRC_INT;
      s_q.out.gear <= GEAR_DIV1;
      s_q.out.periph_a <= PENA_RST;
      s_q.out.periph_b <= PENB_RST;
    end
    else if (ce_i)
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o = s_q.wready;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign clk_ctl_o = s_q.out;

endmodule

// ### logic/cg_pkg.sv
package cg_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IRQ_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_SYS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OSC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STBY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PLLSEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PLLSET = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WUP = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PENA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PENB = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EXT = 8'h20;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int GEAR_LSB = 0;
  localparam int GEAR_W = 3;
  localparam int OSC_IOSC_BIT = 0;
  localparam int OSC_EOSC_LSB = 1;
  localparam int EOSC_W = 2;
  localparam int OSC_SEL_BIT = 8;
  localparam int OSC_FLAG_BIT = 9;
  localparam int STBY_LSB = 0;
  localparam int STBY_W = 2;
  localparam int PLL_SEL_BIT = 0;
  localparam int PLL_ST_BIT = 1;
  localparam int PLL_ON_BIT = 2;
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 24;
  localparam int WU_START_BIT = 0;
  localparam int WU_FLAG_BIT = 1;
  localparam int WU_CLK_BIT = 8;
  localparam int WUPT_LSB = 16;
  localparam int WUPT_W = 16;
  localparam int EXT_HALF_BIT = 4;
  localparam int EXT_TMR_BIT = 5;

  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [GEAR_W-1:0] GEAR_DIV1 = 3'h0;
  localparam logic [EOSC_W-1:0] EOSC_OFF = 2'h0;
  localparam logic [DATA_W-1:0] PENA_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PENB_RST = 32'hf000_0000;
  localparam logic [STBY_W-1:0] STBY_IDLE = 2'h0;
  localparam logic [STBY_W-1:0] STBY_DEEP = 2'h1;
  localparam logic [MULT_W-1:0] MULT_X12 = 24'hc60b00;
  localparam logic [MULT_W-1:0] MULT_X8 = 24'hc60700;
  localparam logic [MULT_W-1:0] MULT_X6 = 24'hc60500;
  localparam logic [WUPT_W-1:0] WUPT_RST = 16'h0000;

  // ------------------------------------------------------------
  // Switch-over delays in clk_i cycles
  // ------------------------------------------------------------
  localparam int SW_CNT_W = 4;
  localparam logic [SW_CNT_W-1:0] GEAR_SW_CYC = 4'h4;
  localparam logic [SW_CNT_W-1:0] OSC_SW_CYC = 4'h8;
  localparam logic [SW_CNT_W-1:0] PLL_SW_CYC = 4'h8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CG_SRC_INT = 2'b00,
    CG_SRC_EXT = 2'b01,
    CG_SRC_EXT_HALF = 2'b10,
    CG_SRC_PLL = 2'b11
  } cg_src_t;

  typedef enum logic [1:0] {
    CG_MUL_OFF = 2'b00,
    CG_MUL_6 = 2'b01,
    CG_MUL_8 = 2'b10,
    CG_MUL_12 = 2'b11
  } cg_mul_t;

  typedef enum logic [1:0] {
    CG_PM_NORMAL = 2'b00,
    CG_PM_STOP = 2'b01,
    CG_PM_WARM = 2'b10
  } cg_pm_t;

  typedef struct packed {
    logic iosc_en;
    logic [EOSC_W-1:0] eosc_en;
    logic pll_power;
    cg_mul_t pll_mul;
    cg_src_t fc_src;
    logic [GEAR_W-1:0] gear;
    logic [DATA_W-1:0] periph_a;
    logic [DATA_W-1:0] periph_b;
    logic timer_pll_en;
    logic stop;
    logic wake;
    logic [IRQ_W-1:0] wake_id;
  } cg_clk_out_t;

endpackage

// ### logic/cg_timer.sv
`timescale 1ns/1ns
module cg_timer
  import cg_pkg::*;
#(
  parameter int W = WUPT_W
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Load and count
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic busy_o,
  output logic done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } cg_tmr_state_t;

  cg_tmr_state_t s_q;
  cg_tmr_state_t s_d;

  // Value N gives done N+2 cycles after load
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load_i)
    begin
      s_d.cnt = value_i;
      s_d.busy = 1'b1;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;

endmodule

// ### testbench/cg_clock_gen_checker.sv
`timescale 1ns/1ns
module cg_clock_gen_checker
  import cg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Clock controls
  input wire cg_clk_out_t clk_ctl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_answer;
    s_wr_take |=> !s_axi_awready_o ##1 s_axi_bvalid_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_unmapped;
    s_rd_take ##0 s_axi_araddr_i > OFF_EXT |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_reset;
    $rose(resetn_i) |-> clk_ctl_o.iosc_en && clk_ctl_o.eosc_en == EOSC_OFF && !clk_ctl_o.pll_power
      && clk_ctl_o.gear == GEAR_DIV1 && clk_ctl_o.fc_src == CG_SRC_INT
      && clk_ctl_o.periph_b == PENB_RST;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_pll_src;
    clk_ctl_o.fc_src == CG_SRC_PLL |-> clk_ctl_o.pll_power && clk_ctl_o.pll_mul != CG_MUL_OFF;
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("unpowered pll selected");
  property p_gear_delay;
    s_wr_take ##0 s_axi_awaddr_i == OFF_SYS |=> $stable(clk_ctl_o.gear) [*2];
  endproperty
  a_gear_delay: assert property (p_gear_delay) else $error("gear switched at once");
  property p_wake_pulse;
    clk_ctl_o.wake |=> !clk_ctl_o.wake && !clk_ctl_o.stop && $stable(clk_ctl_o.wake_id);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  property p_stop_off;
    clk_ctl_o.stop |-> !clk_ctl_o.pll_power && clk_ctl_o.eosc_en == EOSC_OFF;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("clock left on in stop");
endmodule

bind cg_clock_gen cg_clock_gen_checker cg_clock_gen_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .clk_ctl_o(clk_ctl_o)
);

// ### testbench/cg_clock_gen_tb.sv
`timescale 1ns/1ns
module cg_clock_gen_tb
  import cg_pkg::*;
;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd_val;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic sleep = 1'h0, irq = 1'h0;
  logic [IRQ_W-1:0] irq_id = '0, irq_num;
  logic awready, wready, bvalid, arready, rvalid, wfi, irq_valid;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  cg_clk_out_t ctl;
  int errors = 0, tests_run = 0;
  logic [MULT_W-1:0] codes [3] = '{MULT_X12, MULT_X8, MULT_X6};
  cg_mul_t muls [3] = '{CG_MUL_12, CG_MUL_8, CG_MUL_6};

  cg_clock_gen cg_clock_gen_i (
    .clk_i(clk), .resetn_i(resetn), .ce_i(1'h1), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .wfi_i(wfi), .wake_irq_valid_i(irq_valid),
    .wake_irq_id_i(irq_num), .clk_ctl_o(ctl));
  cg_core_model cg_core_model_i (
    .clk_i(clk), .resetn_i(resetn), .sleep_i(sleep), .irq_i(irq), .id_i(irq_id),
    .wake_i(ctl.wake), .wfi_o(wfi), .irq_valid_o(irq_valid), .irq_id_o(irq_num));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up(input logic ok);
    tests_run++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("Error wait expected done seen timeout");
      end_sim();
    end
  endtask
  // Sampling on the falling edge keeps the handshake free of update races
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    logic ha, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    for (k = 0; k < 40 && !hb; k++)
    begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      wr_resp = bresp;
      @(posedge clk);
      if (ha)
        awvalid <= 1'h0;
      if (hw)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    give_up(hb);
  endtask
  // Ready is raised late on purpose so the answer must stand a cycle
  task automatic rd(input logic [ADDR_W-1:0] a);
    int k;
    logic ha, hr, rv;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    hr = 1'h0;
    for (k = 0; k < 40 && !hr; k++)
    begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid & rready;
      rv = rvalid;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge clk);
      if (ha)
        arvalid <= 1'h0;
      rready <= rv & !hr;
    end
    give_up(hr);
  endtask
  task automatic poll(input logic [ADDR_W-1:0] a, input int b, input logic v);
    int k;
    for (k = 0; k < 30; k++)
    begin
      rd(a);
      if (rd_val[b] === v)
        break;
    end
    give_up(rd_val[b] === v);
  endtask
  task automatic wait_src(input cg_src_t s);
    int k;
    for (k = 0; k < 30 && ctl.fc_src !== s; k++)
      @(negedge clk);
    give_up(ctl.fc_src === s);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(negedge clk);
    chk("state", {ctl.iosc_en, ctl.eosc_en, ctl.pll_power, ctl.gear, ctl.fc_src},
      {1'h1, EOSC_OFF, 1'h0, GEAR_DIV1, CG_SRC_INT});
    chk("periph_a", ctl.periph_a, PENA_RST);
    rd(OFF_PENB);
    chk("periph_b", rd_val, PENB_RST);
    wr(OFF_PENA, 32'h0000_3f80);
    rd(OFF_PENA);
    chk("periph_a", ctl.periph_a, 32'h0000_3f80);
  endtask
  task automatic t_bus;
    wr(8'h40, 32'hffff_ffff);
    chk("bresp", wr_resp, RESP_SLVERR);
    rd(8'h40);
    chk("rresp", rd_resp, RESP_SLVERR);
    chk("rdata", rd_val, 32'h0);
  endtask
  task automatic t_gear;
    int k;
    wr(OFF_SYS, 32'h0000_0003);
    for (k = 0; k < 20 && ctl.gear !== 3'h3; k++)
      @(negedge clk);
    give_up(ctl.gear === 3'h3);
    wr(OFF_SYS, 32'h0);
  endtask
  task automatic t_pll;
    wr(OFF_PLLSEL, 32'h4);
    rd(OFF_PLLSEL);
    chk("pll_power", ctl.pll_power, 1'h0);
    wr(OFF_PLLSEL, 32'h0);
    wr(OFF_OSC, 32'h0000_0103);
    poll(OFF_OSC, OSC_FLAG_BIT, 1'h1);
    wait_src(CG_SRC_EXT);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_PLLSET, {8'h0, codes[i]});
      wr(OFF_PLLSEL, 32'h4);
      wr(OFF_PLLSEL, 32'h5);
      poll(OFF_PLLSEL, PLL_ST_BIT, 1'h1);
      wait_src(CG_SRC_PLL);
      chk("pll_mul", {ctl.pll_power, ctl.pll_mul}, {1'h1, muls[i]});
      wr(OFF_PLLSEL, 32'h4);
      poll(OFF_PLLSEL, PLL_ST_BIT, 1'h0);
      wr(OFF_PLLSEL, 32'h0);
    end
  endtask
  task automatic t_ext;
    wr(OFF_EXT, 32'h0000_0030);
    wait_src(CG_SRC_EXT_HALF);
    chk("timer_pll_en", ctl.timer_pll_en, 1'h0);
    wr(OFF_EXT, 32'h0);
    wait_src(CG_SRC_EXT);
  endtask
  task automatic t_stop;
    int k;
    wr(OFF_WUP, 32'h0010_0001);
    poll(OFF_WUP, WU_FLAG_BIT, 1'h1);
    wr(OFF_OSC, 32'h0000_0001);
    poll(OFF_OSC, OSC_FLAG_BIT, 1'h0);
    wr(OFF_STBY, {30'h0, STBY_DEEP});
    sleep <= 1'h1;
    irq_id <= 6'h2a;
    for (k = 0; k < 30 && ctl.stop !== 1'h1; k++)
      @(negedge clk);
    give_up(ctl.stop === 1'h1);
    @(posedge clk);
    sleep <= 1'h0;
    irq <= 1'h1;
    @(posedge clk);
    irq <= 1'h0;
    for (k = 0; k < 200 && ctl.wake !== 1'h1; k++)
      @(negedge clk);
    give_up(ctl.wake === 1'h1);
    chk("wake_id", ctl.wake_id, 6'h2a);
    chk("iosc_en", ctl.iosc_en, 1'h1);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    t_reset();
    t_bus();
    t_gear();
    t_pll();
    t_ext();
    t_stop();
    end_sim();
  end
endmodule

// ### testbench/cg_core_model.sv
`timescale 1ns/1ns
module cg_core_model
  import cg_pkg::*;
(
  // Clock, reset, commands
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sleep_i,
  input wire logic irq_i,
  input wire logic [IRQ_W-1:0] id_i,
  input wire logic wake_i,
  // Core events
  output logic wfi_o,
  output logic irq_valid_o,
  output logic [IRQ_W-1:0] irq_id_o
);
  logic [IRQ_W-1:0] pat_q = '0;
  // Id lines wander while no interrupt is pending
  assign irq_id_o = irq_valid_o ? id_i : pat_q;
  always_ff @(posedge clk_i)
  begin
    pat_q <= pat_q + 6'h1;
    if (!resetn_i || wake_i)
    begin
      wfi_o <= 1'h0;
      irq_valid_o <= 1'h0;
    end
    else
    begin
      wfi_o <= (wfi_o | sleep_i) & !irq_i & !irq_valid_o;
      irq_valid_o <= irq_valid_o | irq_i;
    end
  end
endmodule
